// ===== common/mdsa_cfg.svh
// Register indices, field positions, reset values and cycle counts of the accelerator
`ifndef MDSA_CFG_SVH
`define MDSA_CFG_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define MDSA_IDX_BYTE0   8'hF9
`define MDSA_IDX_BYTE1   8'hFA
`define MDSA_IDX_BYTE2   8'hFB
`define MDSA_IDX_BYTE3   8'hFC
`define MDSA_IDX_BYTE4   8'hFD
`define MDSA_IDX_BYTE5   8'hFE
`define MDSA_IDX_CTRL    8'hFF
`define MDSA_ADDR_W      12

// Local register numbers after decode
`define MDSA_NUM_B0      3'h0
`define MDSA_NUM_B1      3'h1
`define MDSA_NUM_B2      3'h2
`define MDSA_NUM_B3      3'h3
`define MDSA_NUM_B4      3'h4
`define MDSA_NUM_B5      3'h5
`define MDSA_NUM_CTRL    3'h6

// ****************************************************************
// Control/status fields
// ****************************************************************
`define MDSA_SEQERR_BIT  7
`define MDSA_OVF_BIT     6
`define MDSA_DIR_BIT     5
`define MDSA_SC_MSB      4
`define MDSA_SC_LSB      0
`define MDSA_RST_BYTE    8'h00
`define MDSA_RST_SC      5'h00

// ****************************************************************
// Latencies in clocks, counted from the final load write, and result limits
// ****************************************************************
`define MDSA_LAT_DIV32   5'd17
`define MDSA_LAT_DIV16   5'd9
`define MDSA_LAT_MUL     5'd10
`define MDSA_LAT_BASE    5'd3
`define MDSA_MUL_LIMIT   32'h0000_FFFF
`define MDSA_DIV0_QUOT   32'hFFFF_FFFF
`define MDSA_ZERO_LZ     5'h1F

`endif

// ===== common/mdsa_pkg.sv
// Types shared by the multiply/divide/shift accelerator
package mdsa_pkg;

	// Load sequence tracker: which writes have been seen since byte 0
	typedef enum logic [8:0] {
		LD_IDLE  = 9'b0_0000_0001,
		LD_0     = 9'b0_0000_0010,
		LD_01    = 9'b0_0000_0100,
		LD_012   = 9'b0_0000_1000,
		LD_0123  = 9'b0_0001_0000,
		LD_01234 = 9'b0_0010_0000,
		LD_014   = 9'b0_0100_0000,
		LD_04    = 9'b0_1000_0000,
		LD_041   = 9'b1_0000_0000
	} mdsa_load_t;

	typedef enum logic [2:0] {
		UN_LOAD = 3'b001,
		UN_RUN  = 3'b010,
		UN_READ = 3'b100
	} mdsa_unit_t;

	typedef enum logic [4:0] {
		OP_DIV32 = 5'b0_0001,
		OP_DIV16 = 5'b0_0010,
		OP_MUL   = 5'b0_0100,
		OP_NORM  = 5'b0_1000,
		OP_SHIFT = 5'b1_0000
	} mdsa_op_t;

	// Result held until the latency has run out
	typedef struct packed {
		logic [31:0] lo;
		logic [15:0] hi;
		logic [4:0]  sc;
		logic        ov;
		logic [4:0]  lat;
	} mdsa_result_t;

	// Decoded register select
	typedef struct packed {
		logic       hit;
		logic [2:0] num;
	} mdsa_sel_t;

endpackage

// ===== rtl/mdsa_accel.sv
// Multiply/divide/normalize/shift accelerator with an AHB-Lite register slave
`timescale 1ns/100ps
`include "mdsa_cfg.svh"

module mdsa_accel
	import mdsa_pkg::*;
(
	input  wire logic                     hclk,
	input  wire logic                     hresetn,
	input  wire logic                     hsel,
	input  wire logic [`MDSA_ADDR_W-1:0]  haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic      [31:0]              hrdata,
	output logic                          hreadyout,
	output logic                          hresp
);

	// ****************************************************************
	// Functions
	// ****************************************************************

	function automatic mdsa_sel_t decode(input logic [`MDSA_ADDR_W-1:0] a);
		mdsa_sel_t  s;
		logic [7:0] w;
		s = '0;
		w = a[9:2];
		if (a[`MDSA_ADDR_W-1:10] == 2'b00 && a[1:0] == 2'b00 &&
			w >= `MDSA_IDX_BYTE0 && w <= `MDSA_IDX_CTRL) begin
			s.hit = 1'b1;
			s.num = 3'(w - `MDSA_IDX_BYTE0);
		end
		return s;
	endfunction

	function automatic logic [4:0] lead_zeros(input logic [31:0] v);
		logic [4:0] n;
		logic       found;
		n = 5'd0;
		found = 1'b0;
		for (int i = 31; i >= 0; i--) begin
			if (!found) begin
				if (v[i]) begin
					found = 1'b1;
				end else if (n != 5'd31) begin
					n = n + 5'd1;
				end
			end
		end
		return n;
	endfunction

	// Full result is worked out at start, then held for the documented latency
	function automatic mdsa_result_t compute(input mdsa_op_t op, input logic [31:0] a,
		input logic [15:0] b, input logic dir, input logic [4:0] sc);
		mdsa_result_t r;
		logic [31:0]  prod;
		logic [4:0]   lz;
		r = '0;
		r.hi = b;
		r.sc = sc;
		prod = 32'(a[15:0]) * 32'(b);
		lz = lead_zeros(a);
		unique case (op)
			OP_DIV32, OP_DIV16: begin
				if (b == 16'h0000) begin
					r.lo = `MDSA_DIV0_QUOT;
					r.hi = a[15:0];
					r.ov = 1'b1;
				end else begin
					r.lo = a / 32'(b);
					r.hi = 16'(a % 32'(b));
				end
				r.lat = (op == OP_DIV32) ? `MDSA_LAT_DIV32 : `MDSA_LAT_DIV16;
			end
			OP_MUL: begin
				r.lo = prod;
				r.ov = (prod > `MDSA_MUL_LIMIT);
				r.lat = `MDSA_LAT_MUL;
			end
			OP_NORM: begin
				r.lo = a << lz;
				r.sc = (a == 32'h0000_0000) ? `MDSA_ZERO_LZ : lz;
				r.ov = a[31];
				r.lat = `MDSA_LAT_BASE + 5'((6'(lz) + 6'd1) >> 1);
			end
			OP_SHIFT: begin
				r.lo = dir ? (a >> sc) : (a << sc);
				r.lat = `MDSA_LAT_BASE + (sc >> 1);
			end
		endcase
		return r;
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************

	logic [7:0]   md_r [0:5];
	logic         dir_r;
	logic [4:0]   sc_r;
	logic         seqerr_r;
	logic         ovf_r;
	logic         errwin_r;
	mdsa_load_t   load_r;
	mdsa_load_t   load_nxt;
	mdsa_unit_t   unit_r;
	mdsa_op_t     op_r;
	logic [4:0]   cnt_r;
	mdsa_result_t res_r;
	mdsa_result_t res_nxt;
	mdsa_sel_t    wsel_r;
	mdsa_sel_t    rsel_r;
	logic         wpend_r;
	logic         rpend_r;
	logic [31:0]  hrdata_r;
	logic         hreadyout_r;
	logic         hresp_r;

	mdsa_sel_t    asel;
	logic         addr_take;
	logic         wr_fire;
	logic         wr_md;
	logic         wr_ctrl;
	logic         rd_fire;
	logic [7:0]   wbyte;
	logic         abort;
	logic         commit;
	logic         start;
	mdsa_op_t     start_op;
	logic [31:0]  opa;
	logic [15:0]  opb;
	logic [2:0]   last_num;
	logic         finish;
	logic [7:0]   ctrl_val;

	// ****************************************************************
	// Bus slave
	// ****************************************************************

	assign asel      = decode(haddr);
	assign addr_take = hsel && htrans[1] && hready;
	assign wbyte     = hwdata[7:0];
	assign wr_fire   = wpend_r && wsel_r.hit;
	assign wr_md     = wr_fire && (wsel_r.num != `MDSA_NUM_CTRL);
	assign wr_ctrl   = wr_fire && (wsel_r.num == `MDSA_NUM_CTRL);
	assign rd_fire   = rpend_r && rsel_r.hit;
	assign ctrl_val  = {seqerr_r, ovf_r, dir_r, sc_r};

	// Reads take one wait state so a write just before them has already landed
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wpend_r     <= 1'b0;
			rpend_r     <= 1'b0;
			wsel_r      <= '0;
			rsel_r      <= '0;
			hreadyout_r <= 1'b1;
			hresp_r     <= 1'b0;
		end else begin
			wpend_r     <= addr_take && hwrite;
			rpend_r     <= addr_take && !hwrite;
			wsel_r      <= asel;
			rsel_r      <= asel;
			hreadyout_r <= !(addr_take && !hwrite);
			hresp_r     <= 1'b0;
		end
	end

	// Unmapped reads return zero; narrow sizes are served as whole words
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_r <= 32'h0000_0000;
		end else if (rpend_r) begin
			if (!rsel_r.hit) begin
				hrdata_r <= 32'h0000_0000;
			end else if (rsel_r.num == `MDSA_NUM_CTRL) begin
				hrdata_r <= {24'h00_0000, ctrl_val};
			end else begin
				hrdata_r <= {24'h00_0000, md_r[rsel_r.num]};
			end
		end
	end

	assign hrdata    = hrdata_r;
	assign hreadyout = hreadyout_r;
	assign hresp     = hresp_r;

	// ****************************************************************
	// Load sequence tracking
	// ****************************************************************

	always_comb begin
		load_nxt = load_r;
		if (wr_md) begin
			load_nxt = LD_IDLE;
			if (wsel_r.num == `MDSA_NUM_B0) begin
				load_nxt = LD_0;
			end else begin
				unique case (load_r)
					LD_0:    if (wsel_r.num == `MDSA_NUM_B1) load_nxt = LD_01;
						else if (wsel_r.num == `MDSA_NUM_B4) load_nxt = LD_04;
					LD_01:   if (wsel_r.num == `MDSA_NUM_B2) load_nxt = LD_012;
						else if (wsel_r.num == `MDSA_NUM_B4) load_nxt = LD_014;
					LD_012:  if (wsel_r.num == `MDSA_NUM_B3) load_nxt = LD_0123;
					LD_0123: if (wsel_r.num == `MDSA_NUM_B4) load_nxt = LD_01234;
					LD_04:   if (wsel_r.num == `MDSA_NUM_B1) load_nxt = LD_041;
					default: load_nxt = LD_IDLE;
				endcase
			end
		end else if (start) begin
			load_nxt = LD_IDLE;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			load_r <= LD_IDLE;
		end else begin
			load_r <= load_nxt;
		end
	end

	// ****************************************************************
	// Start decode and operands
	// ****************************************************************

	always_comb begin
		start    = 1'b0;
		start_op = OP_SHIFT;
		if (wr_md && wsel_r.num == `MDSA_NUM_B5 && unit_r != UN_RUN) begin
			unique case (load_r)
				LD_01234: begin start = 1'b1; start_op = OP_DIV32; end
				LD_014:   begin start = 1'b1; start_op = OP_DIV16; end
				LD_041:   begin start = 1'b1; start_op = OP_MUL;   end
				default:  start = 1'b0;
			endcase
		end else if (wr_ctrl && load_r == LD_0123 && unit_r != UN_RUN) begin
			start    = 1'b1;
			start_op = (wbyte[`MDSA_SC_MSB:`MDSA_SC_LSB] == 5'h00) ? OP_NORM : OP_SHIFT;
		end
	end

	// The starting write itself is folded into the operands
	always_comb begin
		opa = {md_r[3], md_r[2], md_r[1], md_r[0]};
		opb = (wr_md && wsel_r.num == `MDSA_NUM_B5) ? {wbyte, md_r[4]} : {md_r[5], md_r[4]};
		if (start_op == OP_DIV16) begin
			opa = {16'h0000, md_r[1], md_r[0]};
		end
		res_nxt = compute(start_op, opa, opb, wbyte[`MDSA_DIR_BIT],
			wbyte[`MDSA_SC_MSB:`MDSA_SC_LSB]);
	end

	// ****************************************************************
	// Execution sequencer
	// ****************************************************************

	assign abort    = wr_md && (unit_r == UN_RUN);
	assign commit   = (unit_r == UN_RUN) && (cnt_r == 5'd1) && !wr_md;
	assign last_num = (op_r == OP_DIV32 || op_r == OP_DIV16) ? `MDSA_NUM_B5 : `MDSA_NUM_B3;
	assign finish   = rd_fire && (unit_r == UN_READ) && (rsel_r.num == last_num);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			unit_r <= UN_LOAD;
			op_r   <= OP_SHIFT;
			cnt_r  <= 5'd0;
			res_r  <= '0;
		end else begin
			unique case (unit_r)
				UN_LOAD, UN_READ: begin
					if (start) begin
						unit_r <= UN_RUN;
						op_r   <= start_op;
						cnt_r  <= res_nxt.lat;
						res_r  <= res_nxt;
					end else if (finish) begin
						unit_r <= UN_LOAD;
					end else if (wr_md && wsel_r.num == `MDSA_NUM_B0) begin
						unit_r <= UN_LOAD;
					end
				end
				UN_RUN: begin
					if (abort) begin
						unit_r <= UN_LOAD;
					end else if (commit) begin
						unit_r <= UN_READ;
					end else begin
						cnt_r <= cnt_r - 5'd1;
					end
				end
			endcase
		end
	end

	// ****************************************************************
	// Data bytes
	// ****************************************************************

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 6; i++) begin
				md_r[i] <= `MDSA_RST_BYTE;
			end
		end else if (wr_md) begin
			md_r[wsel_r.num] <= wbyte;
		end else if (commit) begin
			{md_r[3], md_r[2], md_r[1], md_r[0]} <= res_r.lo;
			{md_r[5], md_r[4]} <= res_r.hi;
		end
	end

	// ****************************************************************
	// Control/status register
	// ****************************************************************

	// Direction and count are frozen while running so the result stays consistent
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dir_r <= 1'b0;
			sc_r  <= `MDSA_RST_SC;
		end else if (wr_ctrl && unit_r != UN_RUN) begin
			dir_r <= wbyte[`MDSA_DIR_BIT];
			sc_r  <= wbyte[`MDSA_SC_MSB:`MDSA_SC_LSB];
		end else if (commit && (op_r == OP_NORM || op_r == OP_SHIFT)) begin
			// Divide and multiply keep the count; their start byte is no count
			sc_r <= res_r.sc;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ovf_r <= 1'b0;
		end else if (start) begin
			ovf_r <= 1'b0;
		end else if (commit) begin
			ovf_r <= res_r.ov;
		end
	end

	// Window flag remembers a violation until the window closes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			errwin_r <= 1'b0;
		end else if (abort) begin
			errwin_r <= 1'b1;
		end else if (wr_md && wsel_r.num == `MDSA_NUM_B0) begin
			errwin_r <= 1'b0;
		end
	end

	// A set in the same cycle as a clearing read wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seqerr_r <= 1'b0;
		end else if (abort) begin
			seqerr_r <= 1'b1;
		end else if (rd_fire && rsel_r.num == `MDSA_NUM_CTRL) begin
			seqerr_r <= 1'b0;
		end else if (finish) begin
			seqerr_r <= errwin_r;
		end
	end

endmodule // mdsa_accel

// ===== verif/mdsa_accel_props.sv
// Bus-level assertions for the accelerator register slave
`timescale 1ns/100ps
`include "mdsa_cfg.svh"

module mdsa_accel_props (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp
);
	// ****
	// Transfer and status tracking
	// ****
	localparam logic [11:0] ctrl_a = {2'b00, `MDSA_IDX_CTRL, 2'b00};
	logic        acc;
	logic        wacc;
	logic        rd_done;
	logic        ctrl_done;
	logic        rd_ph_r;
	logic        clean_r;
	logic        err_r;
	logic [3:0]  run_r;
	logic [8:0]  hist_r;
	logic [11:0] a_r;

	assign acc = hsel & htrans[1] & hready;
	assign wacc = acc & hwrite & (haddr[11:5] == 7'h1F);
	assign rd_done = rd_ph_r & hreadyout;
	assign ctrl_done = rd_done & (a_r == ctrl_a);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_ph_r <= 1'b0;
			a_r <= '0;
		end else if (acc) begin
			rd_ph_r <= ~hwrite;
			a_r <= haddr;
		end else if (rd_done) begin
			rd_ph_r <= 1'b0;
		end
	end

	// A multiply load of bytes 0,4,1,5 opens a window shorter than its run
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hist_r <= '0;
			run_r <= '0;
		end else begin
			if (wacc)
				hist_r <= {hist_r[5:0], haddr[4:2]};
			if (wacc && haddr[4:2] == 3'h6 && hist_r == 9'h06A)
				run_r <= 4'h8;
			else if (run_r != 4'h0)
				run_r <= run_r - 4'h1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			err_r <= 1'b0;
			clean_r <= 1'b0;
		end else begin
			clean_r <= (ctrl_done | clean_r) & ~(acc & hwrite);
			if (wacc && run_r != 4'h0 && haddr[4:2] inside {[3'h1:3'h6]})
				err_r <= 1'b1;
			else if (ctrl_done || (wacc && haddr[4:2] == 3'h1))
				err_r <= 1'b0;
		end
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_wait_one;
		!hreadyout ##1 hreadyout;
	endsequence
	property p_okay;
		hresp == 1'b0;
	endproperty
	property p_rd_wait;
		acc && !hwrite |=> s_wait_one;
	endproperty
	property p_wr_nowait;
		acc && hwrite |=> hreadyout;
	endproperty
	property p_rd_upper;
		rd_done |-> hrdata[31:8] == 24'h00_0000;
	endproperty
	property p_rd_hold;
		$changed(hrdata) |-> rd_done;
	endproperty
	property p_unmapped;
		rd_done && a_r[11:2] < 10'h0F9 |-> hrdata == 32'h0000_0000;
	endproperty
	property p_err_clr;
		ctrl_done && clean_r |-> !hrdata[`MDSA_SEQERR_BIT];
	endproperty
	property p_err_set;
		ctrl_done && err_r |-> hrdata[`MDSA_SEQERR_BIT];
	endproperty

	a_okay: assert property (p_okay) else $error("response not OKAY");
	a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
	a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
	a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_err_clr: assert property (p_err_clr) else $error("error flag kept");
	a_err_set: assert property (p_err_set) else $error("error flag missing");
endmodule // mdsa_accel_props

bind mdsa_accel mdsa_accel_props u_props (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp)
);

// ===== verif/mdsa_accel_test.sv
// Self-checking bench for the multiply/divide/shift accelerator
`timescale 1ns/100ps
`include "mdsa_cfg.svh"

module mdsa_accel_test
	import mdsa_pkg::*;
	;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [11:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	int          errors;
	int          num_checks;
	logic [5:0]  ctl_prev;

	mdsa_accel dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
	mdsa_cpu_model u_cpu (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata));

	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	// ****
	// Checking and expectations
	// ****
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rdc(input logic [7:0] idx, input logic [7:0] e, input logic [7:0] m);
		logic [31:0] v;
		u_cpu.rd(idx, v);
		check(v & {24'hFF_FFFF, m}, {24'h00_0000, e & m});
	endtask

	function automatic mdsa_result_t expect_of(input int op, input logic [31:0] a,
		input logic [15:0] b, input logic [7:0] c);
		mdsa_result_t r;
		logic [4:0] n;
		r = '{lo: a, hi: b, sc: c[4:0], ov: 1'b0, lat: 5'd18};
		n = 5'h00;
		if (op < 2) begin
			r.ov = (b == 16'h0000);
			r.lo = r.ov ? 32'hFFFF_FFFF : a / b;
			r.hi = r.ov ? a[15:0] : 16'(a % b);
			r.lat = (op == 1) ? 5'd9 : 5'd17;
		end else if (op == 2) begin
			r.lo = a[15:0] * b;
			r.ov = (r.lo > 32'h0000_FFFF);
			r.lat = 5'd10;
		end else if (c[4:0] == 5'h00) begin
			while (n < 5'h1F && !a[5'h1F - n])
				n++;
			r.lo = a << n;
			r.sc = n;
			r.ov = a[31];
			r.lat = 5'd20;
		end else begin
			r.lo = c[5] ? a >> c[4:0] : a << c[4:0];
		end
		return r;
	endfunction

	task automatic run_op(input int op, input logic [31:0] a, input logic [15:0] b,
		input logic [7:0] c);
		mdsa_result_t e;
		e = expect_of(op, a, b, c);
		u_cpu.load(op, a, b, c);
		// Fixed latencies: operand must still stand one clock before the result lands
		if (op < 3) begin
			repeat (e.lat - 5'd3) @(posedge hclk);
			rdc(`MDSA_IDX_BYTE0, a[7:0], 8'hFF);
		end else begin
			repeat (e.lat) @(posedge hclk);
		end
		rdc(`MDSA_IDX_BYTE0, e.lo[7:0], 8'hFF);
		rdc(`MDSA_IDX_BYTE1, e.lo[15:8], 8'hFF);
		if (op != 1)
			rdc(`MDSA_IDX_BYTE2, e.lo[23:16], 8'hFF);
		if (op != 1)
			rdc(`MDSA_IDX_BYTE3, e.lo[31:24], 8'hFF);
		if (op < 2)
			rdc(`MDSA_IDX_BYTE4, e.hi[7:0], 8'hFF);
		if (op < 2)
			rdc(`MDSA_IDX_BYTE5, e.hi[15:8], 8'hFF);
		// Divide and multiply leave direction and count as they were
		if (op == 3)
			ctl_prev = {c[5], e.sc};
		rdc(`MDSA_IDX_CTRL, {1'b0, e.ov, ctl_prev}, 8'hFF);
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge hclk);
		errors++;
		tally_and_finish();
	end

	// ****
	// Test sequence
	// ****
	initial begin
		logic [31:0] a;
		errors = 0;
		num_checks = 0;
		hresetn = 1'b0;
		void'($urandom(32'h728f_187b));
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 7; i++)
			rdc(`MDSA_IDX_BYTE0 + 8'(i), 8'h00, 8'hFF);
		u_cpu.wr(8'h10, 8'h5A);
		rdc(8'h10, 8'h00, 8'hFF);
		u_cpu.wr(`MDSA_IDX_CTRL, 8'hE5);
		rdc(`MDSA_IDX_CTRL, 8'h25, 8'hFF);
		ctl_prev = 6'h25;
		$display("reset and register test done");
		run_op(0, 32'h1234_5678, 16'h0000, 8'h00);
		run_op(2, 32'h0000_0003, 16'h0005, 8'h00);
		run_op(2, 32'h0000_FFFF, 16'hFFFF, 8'h00);
		run_op(3, 32'h0000_0000, 16'h0000, 8'h00);
		run_op(3, 32'h8000_0001, 16'h0000, 8'h20);
		for (int k = 0; k < 32; k++)
			run_op(3, $urandom, 16'h0000, {2'b00, 1'(k), 5'(k)});
		for (int k = 0; k < 8; k++)
			run_op(3, $urandom >> ($urandom % 32), 16'h0000, 8'h00);
		$display("normalize and shift test done");
		for (int k = 0; k < 30; k++) begin
			a = $urandom;
			if (k % 3 == 1)
				a = a & 32'h0000_FFFF;
			run_op(k % 3, a, 16'($urandom >> ($urandom % 16)), 8'h00);
		end
		$display("divide and multiply test done");
		u_cpu.load(2, 32'h0000_0102, 16'h0304, 8'h00);
		u_cpu.wr(`MDSA_IDX_BYTE0, 8'h11);
		repeat (12) @(posedge hclk);
		rdc(`MDSA_IDX_CTRL, 8'h80, 8'h80);
		rdc(`MDSA_IDX_CTRL, 8'h00, 8'h80);
		u_cpu.load(2, 32'h0000_0102, 16'h0304, 8'h00);
		u_cpu.wr(`MDSA_IDX_BYTE4, 8'h22);
		repeat (12) @(posedge hclk);
		run_op(2, 32'h0000_0102, 16'h0304, 8'h00);
		$display("sequence error test done");
		tally_and_finish();
	end
endmodule // mdsa_accel_test

// ===== verif/mdsa_cpu_model.sv
// CPU-side bus master issuing the accelerator load sequences
`timescale 1ns/100ps
`include "mdsa_cfg.svh"

module mdsa_cpu_model (
	input wire logic        hclk,
	output logic            hsel,
	output logic [11:0]     haddr,
	output logic [1:0]      htrans,
	output logic            hwrite,
	output logic [2:0]      hsize,
	output logic [31:0]     hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata
);
	initial begin
		hsel = 1'b0;
		haddr = 12'h000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
	end

	// ****
	// Single word transfer, entered just after a rising edge
	// ****
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
		output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {2'b00, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		// Idle data lines carry no stale copy of the last word
		hwdata <= ~hwdata;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= {24'h00_0000, d};
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] x;
		xfer(1'b1, idx, d, x);
	endtask

	task automatic rd(input logic [7:0] idx, output logic [31:0] r);
		xfer(1'b0, idx, 8'h00, r);
	endtask

	// op 0 div32, 1 div16, 2 mul, 3 normalize or shift
	task automatic load(input int op, input logic [31:0] a, input logic [15:0] b,
		input logic [7:0] c);
		wr(`MDSA_IDX_BYTE0, a[7:0]);
		if (op == 2) begin
			wr(`MDSA_IDX_BYTE4, b[7:0]);
			wr(`MDSA_IDX_BYTE1, a[15:8]);
		end else begin
			wr(`MDSA_IDX_BYTE1, a[15:8]);
			if (op != 1) begin
				wr(`MDSA_IDX_BYTE2, a[23:16]);
				wr(`MDSA_IDX_BYTE3, a[31:24]);
			end
			if (op < 2)
				wr(`MDSA_IDX_BYTE4, b[7:0]);
		end
		if (op < 3)
			wr(`MDSA_IDX_BYTE5, b[15:8]);
		else
			wr(`MDSA_IDX_CTRL, c);
	endtask
endmodule // mdsa_cpu_model
